// ### hdl/spi_stat_pkg.sv
// Purpose: Shared constants for the serial port status and control block.
// Assumes: 16-bit register port, 8-bit serial words, 20 MHz mclk.
// Notes:   Every offset, field position, reset value and count lives here.
package spi_stat_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 4;

  // Register byte offsets.
  localparam logic [7:0] OFF_STAT  = 8'h00;
  localparam logic [7:0] OFF_DATA  = 8'h04;
  localparam logic [7:0] OFF_CTRL  = 8'h08;
  localparam logic [7:0] OFF_ISTAT = 8'h0c;
  localparam logic [7:0] OFF_IMASK = 8'h10;

  // Status and control register fields.
  localparam int STAT_EN    = 15;
  localparam int STAT_SIDL  = 13;
  localparam int STAT_BEC_L = 8;
  localparam int STAT_SHIFT_REG_EMPTY_FLAG = 7;
  localparam int STAT_ROV   = 6;
  localparam int STAT_RXMPT = 5;
  localparam int STAT_SEL_L = 2;
  localparam int STAT_TBF   = 1;
  localparam int STAT_RBF   = 0;

  // Control register fields.
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_ENH    = 1;

  // Interrupt status and mask fields.
  localparam int IRQ_BUF = 0;
  localparam int IRQ_OVF = 1;

  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [1:0]  CTRL_RESET = 2'h0;
  localparam logic [1:0]  IRQ_RESET  = 2'h0;

  // Condition selector codes.
  localparam logic [2:0] SEL_TX_FULL  = 3'h7;
  localparam logic [2:0] SEL_TX_LAST  = 3'h6;
  localparam logic [2:0] SEL_TX_DONE  = 3'h5;
  localparam logic [2:0] SEL_TX_SLOT  = 3'h4;
  localparam logic [2:0] SEL_RX_FULL  = 3'h3;
  localparam logic [2:0] SEL_RX_3Q    = 3'h2;
  localparam logic [2:0] SEL_RX_AVAIL = 3'h1;
  localparam logic [2:0] SEL_RX_EMPTY = 3'h0;

  localparam logic [2:0] RX_3Q_LEVEL = 3'h3;
  localparam logic [2:0] LIMIT_ENH   = 3'h4;
  localparam logic [2:0] LIMIT_STD   = 3'h1;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  // Serial clock timing in master mode.
  localparam int CLK_NS      = 50;
  localparam int SCK_HALF_NS = 200;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } shift_state_type;
endpackage

// ### hdl/serial_port_status_control.sv
// Purpose: Serial peripheral port with its status and control register.
// Assumes: Mode 0 framing, MSB first, 8-bit words, link pins asynchronous.
// Notes:   Software reaches five registers over a plain strobe port.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Enable bit powers module, hands pins over.
// - Idle-halt bit stops module during idle.
// - Count shows pending or unread transfers.
// - Shift empty flag reads one when idle.
// - Overflow sets, drops word, software clears.
// - Receive empty flag mirrors receive FIFO.
// - Selector 111 interrupts on transmit full.
// - Selector 110 interrupts when transmit empties.
// - Selector 101 interrupts on transmit complete.
// - Selector 100 interrupts on one free slot.
// - Selector 011 interrupts on receive full.
// - Selector 010 interrupts at three quarters.
// - Selector 001 interrupts on data available.
// - Selector 000 interrupts reading last entry.
// - Transmit full flag follows transmit buffer.
// - Receive full flag follows receive buffer.
// - Count and both empty flags read zero unless enhanced.
module serial_port_status_control
  import spi_stat_pkg::*;
(
  input  wire logic                              mclk,
  input  wire logic                              nrst,
  input  wire logic [spi_stat_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [spi_stat_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [spi_stat_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                              idle_req,
  input  wire logic                              sck_in,
  output logic                                   sck_out,
  output logic                                   sck_oe,
  output logic                                   sdo_out,
  output logic                                   sdo_oe,
  input  wire logic                              sdi_in,
  input  wire logic                              sel_n_in,
  output logic                                   irq
);
  import spi_stat_pkg::*;

  // Registers.
  logic                 en_r, sidl_r, rov_r;
  logic [2:0]           irq_condition_select_r;
  logic [1:0]           ctrl_r, ist_r, imask_r;
  logic [DATA_W-1:0]    rdata_r;
  shift_state_type      state_r, state_nxt;
  logic [WORD_W-1:0]    sr_r;
  logic                 sample_r;
  logic [2:0]           bit_r;
  logic [3:0]           div_r;
  logic                 sck_r;
  logic [WORD_W-1:0]    txq_r [FIFO_DEPTH];
  logic [WORD_W-1:0]    rxq_r [FIFO_DEPTH];
  logic [1:0]           tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [2:0]           tx_cnt_r, rx_cnt_r;
  logic                 tx_full_d_r, rx_full_d_r, rx_3q_d_r, rx_any_d_r;
  logic [1:0]           sck_sy_r, sdi_sy_r, sel_sy_r;
  logic                 sck_d_r;

  // Decode of the register port.
  wire logic hit_stat  = (reg_addr == OFF_STAT);
  wire logic hit_data  = (reg_addr == OFF_DATA);
  wire logic hit_ctrl  = (reg_addr == OFF_CTRL);
  wire logic hit_istat = (reg_addr == OFF_ISTAT);
  wire logic hit_imask = (reg_addr == OFF_IMASK);

  // Mode and run decode.
  wire logic master = ctrl_r[CTRL_MASTER];
  wire logic enh    = ctrl_r[CTRL_ENH];
  wire logic halted = idle_req & sidl_r;
  wire logic run    = en_r & ~halted;
  wire logic [2:0] limit = enh ? LIMIT_ENH : LIMIT_STD;

  // Synchronised link inputs; only the second stage is read.
  wire logic sck_s = sck_sy_r[1];
  wire logic sdi_s = sdi_sy_r[1];
  wire logic sel_s = ~sel_sy_r[1];

  // Buffer levels.
  wire logic tx_full  = (tx_cnt_r == limit);
  wire logic rx_full  = (rx_cnt_r == limit);
  wire logic tx_any   = (tx_cnt_r != 3'h0);
  wire logic rx_any   = (rx_cnt_r != 3'h0);
  wire logic rx_3q    = (rx_cnt_r >= RX_3Q_LEVEL);

  // Bus side pushes and pops; a push into a full buffer is dropped.
  wire logic tx_push = reg_wr & hit_data & ~tx_full & en_r;
  wire logic rx_pop  = reg_rd & hit_data & rx_any;

  // Serial clock edges: generated in master mode, sensed in slave mode.
  wire logic div_tick = (state_r == ST_SHIFT) & (div_r == SCK_HALF_LAST);
  wire logic rise_ev  = master ? (div_tick & ~sck_r)
                               : (sck_s & ~sck_d_r & sel_s);
  wire logic fall_ev  = master ? (div_tick & sck_r)
                               : (~sck_s & sck_d_r & sel_s);
  wire logic link_ok  = master | sel_s;

  // A word starts when the shifter is free; a slave shifts zeros if dry.
  wire logic start    = run & (state_r == ST_IDLE) & link_ok
                      & (tx_any | ~master);
  wire logic tx_pop   = start & tx_any;
  wire logic done     = run & (state_r == ST_SHIFT) & fall_ev
                      & (bit_r == LAST_BIT);
  wire logic abort    = (state_r == ST_SHIFT) & (~run | ~link_ok);
  wire logic [WORD_W-1:0] rx_word = {sr_r[WORD_W-2:0], sample_r};
  wire logic rx_push  = done & ~rx_full;
  wire logic ovf_ev   = done & rx_full;

  // Next shifter state; a code that is not one-hot falls back to idle.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (abort | done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Buffer event chosen by the condition selector.
  wire logic ev_tx_full  = tx_full & ~tx_full_d_r;
  wire logic ev_tx_last  = tx_pop & (tx_cnt_r == 3'h1);
  wire logic ev_tx_done  = done;
  wire logic ev_tx_slot  = tx_pop;
  wire logic ev_rx_full  = rx_full & ~rx_full_d_r;
  wire logic ev_rx_3q    = rx_3q & ~rx_3q_d_r;
  wire logic ev_rx_avail = rx_any & ~rx_any_d_r;
  wire logic ev_rx_empty = rx_pop & (rx_cnt_r == 3'h1);
  logic buf_ev;

  // Without the enhanced buffer the selector has no meaning and the
  // event falls back to each received word.
  always_comb begin
    buf_ev = 1'b0;
    if (!enh) begin
      buf_ev = rx_push;
    end else begin
      unique case (irq_condition_select_r)
        SEL_TX_FULL:  buf_ev = ev_tx_full;
        SEL_TX_LAST:  buf_ev = ev_tx_last;
        SEL_TX_DONE:  buf_ev = ev_tx_done;
        SEL_TX_SLOT:  buf_ev = ev_tx_slot;
        SEL_RX_FULL:  buf_ev = ev_rx_full;
        SEL_RX_3Q:    buf_ev = ev_rx_3q;
        SEL_RX_AVAIL: buf_ev = ev_rx_avail;
        SEL_RX_EMPTY: buf_ev = ev_rx_empty;
      endcase
    end
  end

  // Status word as software sees it.
  wire logic [2:0] bec = master ? tx_cnt_r : rx_cnt_r;
  logic [DATA_W-1:0] stat_rd;
  always_comb begin
    stat_rd = 16'h0000;
    stat_rd[STAT_EN]   = en_r;
    stat_rd[STAT_SIDL] = sidl_r;
    stat_rd[STAT_BEC_L +: 3] = enh ? bec : 3'h0;
    stat_rd[STAT_SHIFT_REG_EMPTY_FLAG] = enh & (state_r == ST_IDLE);
    stat_rd[STAT_ROV]   = rov_r;
    stat_rd[STAT_RXMPT] = enh & ~rx_any;
    stat_rd[STAT_SEL_L +: 3] = irq_condition_select_r;
    stat_rd[STAT_TBF]   = tx_full;
    stat_rd[STAT_RBF]   = rx_full;
  end

  // Read data mux; unmapped offsets read zero.
  wire logic [DATA_W-1:0] rd_mux =
      hit_stat  ? stat_rd :
      hit_data  ? {8'h00, rxq_r[rx_rp_r]} :
      hit_ctrl  ? {14'h0000, ctrl_r} :
      hit_istat ? {14'h0000, ist_r} :
      hit_imask ? {14'h0000, imask_r} : 16'h0000;

  wire logic [1:0] ist_set = {ovf_ev, buf_ev};
  wire logic ist_clr = reg_rd & hit_istat;

  // Interrupt level: any unmasked sticky bit.
  assign irq = |(ist_r & imask_r);

  // Pins are handed to the port only while it is enabled.
  assign sck_out = sck_r;
  assign sck_oe  = en_r & master;
  assign sdo_out = sr_r[WORD_W-1];
  assign sdo_oe  = en_r & (master | sel_s);
  assign reg_rdata = rdata_r;

  // Two-flop synchronisers for the link pins.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sck_sy_r <= 2'h0;
      sdi_sy_r <= 2'h0;
      sel_sy_r <= 2'h3;
      sck_d_r  <= 1'b0;
    end else begin
      sck_sy_r <= {sck_sy_r[0], sck_in};
      sdi_sy_r <= {sdi_sy_r[0], sdi_in};
      sel_sy_r <= {sel_sy_r[0], sel_n_in};
      sck_d_r  <= sck_s;
    end
  end

  // Software writable fields; unimplemented bits are never stored.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_r    <= STAT_RESET[STAT_EN];
      sidl_r  <= STAT_RESET[STAT_SIDL];
      irq_condition_select_r <= STAT_RESET[STAT_SEL_L +: 3];
      ctrl_r  <= CTRL_RESET;
      imask_r <= IRQ_RESET;
    end else if (reg_wr) begin
      if (hit_stat) begin
        en_r    <= reg_wdata[STAT_EN];
        sidl_r  <= reg_wdata[STAT_SIDL];
        irq_condition_select_r <= reg_wdata[STAT_SEL_L +: 3];
      end
      if (hit_ctrl) begin
        ctrl_r <= reg_wdata[1:0];
      end
      if (hit_imask) begin
        imask_r <= reg_wdata[1:0];
      end
    end
  end

  // Overflow flag: hardware sets, software writes zero to clear, set wins.
  wire logic rov_clr = reg_wr & hit_stat & ~reg_wdata[STAT_ROV];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rov_r <= STAT_RESET[STAT_ROV];
    end else begin
      rov_r <= ovf_ev | (rov_r & ~rov_clr);
    end
  end

  // Sticky interrupt bits, cleared by reading them; a new event wins.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ist_r <= IRQ_RESET;
    end else begin
      ist_r <= ist_set | (ist_clr ? 2'h0 : ist_r);
    end
  end

  // Registered read data, valid the cycle after the read strobe.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // Transmit buffer; turning the port off flushes it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_wp_r  <= 2'h0;
      tx_rp_r  <= 2'h0;
      tx_cnt_r <= 3'h0;
    end else if (!en_r) begin
      tx_wp_r  <= 2'h0;
      tx_rp_r  <= 2'h0;
      tx_cnt_r <= 3'h0;
    end else begin
      if (tx_push) begin
        tx_wp_r <= tx_wp_r + 2'h1;
      end
      if (tx_pop) begin
        tx_rp_r <= tx_rp_r + 2'h1;
      end
      tx_cnt_r <= tx_cnt_r + {2'h0, tx_push} - {2'h0, tx_pop};
    end
  end

  // Receive buffer; a full buffer drops the new word instead.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_wp_r  <= 2'h0;
      rx_rp_r  <= 2'h0;
      rx_cnt_r <= 3'h0;
    end else if (!en_r) begin
      rx_wp_r  <= 2'h0;
      rx_rp_r  <= 2'h0;
      rx_cnt_r <= 3'h0;
    end else begin
      if (rx_push) begin
        rx_wp_r <= rx_wp_r + 2'h1;
      end
      if (rx_pop) begin
        rx_rp_r <= rx_rp_r + 2'h1;
      end
      rx_cnt_r <= rx_cnt_r + {2'h0, rx_push} - {2'h0, rx_pop};
    end
  end

  // Buffer storage needs no reset; the counts guard every pop, but a data read of an empty receive buffer returns raw storage.
  always_ff @(posedge mclk) begin
    if (tx_push) begin
      txq_r[tx_wp_r] <= reg_wdata[WORD_W-1:0];
    end
    if (rx_push) begin
      rxq_r[rx_wp_r] <= rx_word;
    end
  end

  // Level history for the rising-edge buffer events.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_full_d_r <= 1'b0;
      rx_full_d_r <= 1'b0;
      rx_3q_d_r   <= 1'b0;
      rx_any_d_r  <= 1'b0;
    end else begin
      tx_full_d_r <= tx_full;
      rx_full_d_r <= rx_full;
      rx_3q_d_r   <= rx_3q;
      rx_any_d_r  <= rx_any;
    end
  end

  // Shift engine: sample on the rising edge, shift on the falling one.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= ST_IDLE;
      sr_r     <= 8'h00;
      sample_r <= 1'b0;
      bit_r    <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        sr_r  <= tx_any ? txq_r[tx_rp_r] : 8'h00;
        bit_r <= 3'h0;
      end else if (state_r == ST_SHIFT) begin
        if (rise_ev) begin
          sample_r <= sdi_s;
        end
        if (fall_ev) begin
          sr_r  <= rx_word;
          bit_r <= bit_r + 3'h1;
        end
      end
    end
  end

  // Master clock divider; the clock idles low between words.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 4'h0;
      sck_r <= 1'b0;
    end else if (state_r != ST_SHIFT || !master || !run) begin
      div_r <= 4'h0;
      sck_r <= 1'b0;
    end else if (div_tick) begin
      div_r <= 4'h0;
      sck_r <= ~sck_r;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
endmodule

`default_nettype wire

// ### bench/spi_stat_checker_properties.sv
// Purpose: Port-level checks of the serial port status block.
// Assumes: One clock domain, mclk, with nrst as its asynchronous reset.
// Notes:   Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module spi_stat_checker
  import spi_stat_pkg::*;
(
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] reg_wdata,
  input wire logic [7:0]  reg_addr,
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        sdo_oe,
  input wire logic        irq
);
  // Decoded accesses, named so the properties stay short.
  wire logic stat_rd = reg_rd && reg_addr == OFF_STAT;
  wire logic stat_wr = reg_wr && reg_addr == OFF_STAT;
  wire logic mapped  = reg_addr inside {OFF_STAT, OFF_DATA, OFF_CTRL,
                                        OFF_ISTAT, OFF_IMASK};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_unmapped_zero: assert property (
    reg_rd && !mapped |=> reg_rdata == 16'h0000) else $error("unmapped read");
  a_stat_gaps_zero: assert property (
    stat_rd |=> {reg_rdata[14], reg_rdata[12:11]} == 3'h0)
    else $error("reserved status bits set");
  a_data_upper_zero: assert property (
    reg_rd && reg_addr == OFF_DATA |=> reg_rdata[15:8] == 8'h00)
    else $error("data upper byte set");
  a_disable_frees_pins: assert property (
    stat_wr && !reg_wdata[STAT_EN] |=> !sck_oe && !sdo_oe)
    else $error("pins kept after disable");
  a_enable_reads_back: assert property (
    stat_rd && sck_oe |=> reg_rdata[STAT_EN]) else $error("enable not shown");
  a_count_bound: assert property (
    stat_rd |=> reg_rdata[10:8] <= 3'h4) else $error("count above depth");
  a_rxfull_not_empty: assert property (
    stat_rd |=> (reg_rdata[STAT_RBF] -> !reg_rdata[STAT_RXMPT]))
    else $error("full and empty together");
  a_shift_busy_clock: assert property (
    stat_rd && sck_out |=> !reg_rdata[STAT_SHIFT_REG_EMPTY_FLAG])
    else $error("shifter empty mid word");
  a_clock_needs_pin: assert property (
    $rose(sck_out) |-> sck_oe) else $error("clock while pin released");
  a_irq_drop_access: assert property (
    $fell(irq) |-> $past(reg_rd) || $past(reg_wr))
    else $error("interrupt dropped alone");
  a_irq_read_shows: assert property (
    reg_rd && reg_addr == OFF_ISTAT && irq |=> reg_rdata[1:0] != 2'h0)
    else $error("interrupt without status");

  // Main scenarios reached.
  c_overflow: cover property (stat_rd ##1 reg_rdata[STAT_ROV]);
  c_tx_full: cover property (stat_rd ##1 reg_rdata[STAT_TBF]);
  c_irq: cover property ($rose(irq));
endmodule

bind serial_port_status_control spi_stat_checker chk_i (
  .reg_rdata(reg_rdata), .reg_wdata(reg_wdata), .reg_addr(reg_addr),
  .mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe), .irq(irq));
`default_nettype wire

// ### bench/link_peer.sv
// Purpose: Serial peer on the far side of the port's link pins.
// Assumes: Mode 0, MSB first, 8-bit words.
// Notes:   Answers a master port; frame() clocks the port as a slave.
`timescale 1ns/10ps
`default_nettype none
module link_peer (
  input  wire logic       sck_out,
  input  wire logic       sdo_out,
  output logic            sck_in,
  output logic            sdi_in,
  output logic            sel_n_in,
  output logic [7:0]      got,
  output logic [7:0]      reply
);
  int idx;
  logic armed;

  // Idle pins; select starts inactive so the port is not addressed.
  initial begin
    sck_in = 1'b0;
    sel_n_in = 1'b1;
    got = 8'h00;
    reply = 8'ha5;
    idx = 0;
    armed = 1'b0;
    sdi_in = 1'b1;
  end

  // Capture on the rising clock, present the next bit on the falling one.
  // Only a fall that follows a rise counts, so the unknown-to-low step of
  // the clock at reset does not skew the bit count.
  always @(posedge sck_out) begin
    got <= {got[6:0], sdo_out};
    armed = 1'b1;
  end
  always @(negedge sck_out) begin
    if (armed) begin
      armed = 1'b0;
      idx = (idx + 1) % 8;
      if (idx == 0) begin
        reply = reply + 8'h01;
      end
      sdi_in = reply[7 - idx];
    end
  end

  // One word clocked at 400 ns, phase unrelated to mclk.
  task automatic frame(input logic [7:0] b);
    #37 sel_n_in = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi_in = b[i];
      #200 sck_in = 1'b1;
      got = {got[6:0], sdo_out};
      #200 sck_in = 1'b0;
    end
    #200 sel_n_in = 1'b1;
    sdi_in = ~b[0];
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench of the serial port status block.
// Assumes: 20 MHz mclk, register reads answered one cycle later.
// Notes:   A link peer answers master words and clocks one slave word.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import spi_stat_pkg::*;
  logic        mclk, nrst, reg_wr, reg_rd, idle_req, irq;
  logic        sck_in, sck_out, sck_oe, sdo_out, sdo_oe, sdi_in, sel_n_in;
  logic [7:0]  reg_addr, got, reply, rep;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [7:0]  e_ev, e_rd;
  int          bad_count, check_count;

  serial_port_status_control dut (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_req(idle_req),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdi_in(sdi_in),
    .sel_n_in(sel_n_in), .irq(irq));
  link_peer peer (.sck_out(sck_out), .sdo_out(sdo_out), .sck_in(sck_in),
    .sdi_in(sdi_in), .sel_n_in(sel_n_in), .got(got), .reply(reply));

  // 50 ns clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Counts every comparison; an unknown seen value never matches.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus cycles change signals just after an edge and hold one cycle.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(v, e, $sformatf("register %h", a));
  endtask
  // Bounded poll until the shifter is idle with nothing pending.
  task automatic word_wait;
    for (int i = 0; i < 250; i++) begin
      rd(OFF_STAT);
      if (v[STAT_SHIFT_REG_EMPTY_FLAG] && v[10:8] == 3'h0) break;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run of about 65 us.
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    idle_req = 1'b0;
    rep = 8'ha5;
    e_ev = 8'h72;
    e_rd = 8'h01;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rc(OFF_STAT, STAT_RESET);
    rc(8'h14, 16'h0000);
    wr(OFF_STAT, 16'h7fff);
    rc(OFF_STAT, 16'h201c);
    wr(OFF_CTRL, 16'h0003);
    wr(OFF_IMASK, 16'h0001);
    // One master word under every selector code.
    for (int s = 0; s < 8; s++) begin
      wr(OFF_STAT, 16'h8000 | 16'(s << 2));
      rd(OFF_ISTAT);
      rc(OFF_STAT, 16'h80a0 | 16'(s << 2));
      chk(16'({sck_oe, sdo_oe}), 16'h0003, "pin enables");
      wr(OFF_DATA, 16'h00c3 ^ 16'(s));
      word_wait();
      chk(16'(got), 16'h00c3 ^ 16'(s), "peer word");
      chk(16'(irq), 16'(e_ev[s]), "interrupt line");
      rc(OFF_ISTAT, 16'(e_ev[s]));
      rc(OFF_STAT, 16'h8080 | 16'(s << 2));
      rc(OFF_DATA, 16'(rep));
      rep++;
      rc(OFF_ISTAT, 16'(e_rd[s]));
    end
    // Idle halt holds a pending word until idle ends.
    wr(OFF_STAT, 16'ha000);
    idle_req <= 1'b1;
    wr(OFF_DATA, 16'h0011);
    repeat (100) @(posedge mclk);
    rc(OFF_STAT, 16'ha1a0);
    idle_req <= 1'b0;
    word_wait();
    rc(OFF_DATA, 16'(rep));
    rep++;
    rd(OFF_ISTAT);
    // Fill the transmit side, overflow the receive side.
    wr(OFF_STAT, 16'h801c);
    rd(OFF_ISTAT);
    for (int i = 0; i < 5; i++) wr(OFF_DATA, 16'h0040 + 16'(i));
    rc(OFF_STAT, 16'h843e);
    rc(OFF_ISTAT, 16'h0001);
    word_wait();
    chk(16'(got), 16'h0044, "last peer word");
    rc(OFF_STAT, 16'h80dd);
    chk(16'(irq), 16'h0000, "masked overflow line");
    rc(OFF_ISTAT, 16'h0002);
    wr(OFF_STAT, 16'h801c);
    rc(OFF_STAT, 16'h809d);
    for (int i = 0; i < 4; i++) begin
      rc(OFF_DATA, 16'(rep));
      rep++;
    end
    rc(OFF_STAT, 16'h80bc);
    // Slave word clocked by the peer.
    wr(OFF_CTRL, 16'h0002);
    peer.frame(8'h5a);
    repeat (10) @(posedge mclk);
    rc(OFF_STAT, 16'h819c);
    chk(16'({sck_oe, got}), 16'h0000, "slave clock and reply");
    rc(OFF_DATA, 16'h005a);
    wr(OFF_STAT, 16'h0000);
    chk(16'({sck_oe, sdo_oe}), 16'h0000, "released pins");
    tally_and_finish();
  end
endmodule
`default_nettype wire
